// *** dv/qdl_core_monitor.sv ***
// Purpose: port assertions of the quad load logic
// Assumes: serial build; pins pass a three-flop synchroniser
// Notes:   eight-cycle windows on the pin inputs absorb the synchroniser delay
`timescale 1ns/1ps
`default_nettype none
module qdl_core_checker (
    input wire logic                    clk_i,
    input wire logic                    reset_i,
    input wire logic                    serial_in_floating_i,
    input wire logic                    load_strobe_n_i,
    input wire logic                    clear_all_n_i,
    input wire logic                    chip_select_n_i,
    input wire qdl_pkg::qdl_bank_t      input_reg_o,
    input wire qdl_pkg::qdl_bank_t      dac_reg_o,
    input wire qdl_pkg::qdl_chan_mask_t out_enable_o,
    input wire logic                    hw_powerdown_o
);
    import qdl_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_clear_zeroes_input: assert property (!clear_all_n_i [*8] |-> input_reg_o == '0)
        else $error("input not cleared");
    a_clear_zeroes_dac: assert property (!clear_all_n_i [*8] |-> dac_reg_o == '0)
        else $error("dac not cleared");
    a_dac_follows_input: assert property ((!load_strobe_n_i && clear_all_n_i
        && $stable(input_reg_o)) [*8] |-> dac_reg_o == input_reg_o) else $error("dac lags");
    a_dac_holds_code: assert property ((load_strobe_n_i && clear_all_n_i) [*8]
        |=> $stable(dac_reg_o)) else $error("dac moved");
    a_idle_no_commit: assert property ((chip_select_n_i && clear_all_n_i) [*8]
        |=> $stable(input_reg_o)) else $error("input moved while idle");
    a_float_powers_down: assert property (serial_in_floating_i [*8] |-> hw_powerdown_o)
        else $error("no shutdown");
    a_driven_runs: assert property (!serial_in_floating_i [*8] |-> !hw_powerdown_o)
        else $error("stray shutdown");
    a_shutdown_opens: assert property (hw_powerdown_o [*2] |-> out_enable_o == '0)
        else $error("output driven in shutdown");
endmodule
bind qdl_core qdl_core_checker chk_u (.clk_i(clk_i), .reset_i(reset_i),
    .serial_in_floating_i(serial_in_floating_i), .load_strobe_n_i(load_strobe_n_i),
    .clear_all_n_i(clear_all_n_i), .chip_select_n_i(chip_select_n_i),
    .input_reg_o(input_reg_o), .dac_reg_o(dac_reg_o), .out_enable_o(out_enable_o),
    .hw_powerdown_o(hw_powerdown_o));
`default_nettype wire

// *** dv/qdl_host_model.sv ***
// Purpose: host side of the serial link
// Assumes: link clock runs only inside a frame, 15 ns period
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
`include "qdl_defines.svh"
module qdl_host_model (
    output var logic sclk_o = 1'b0,
    output var logic chip_select_n_o = 1'b1,
    output var logic serial_o = 1'b0,
    output var logic floating_o = 1'b0
);
    import qdl_pkg::*;
    // select stays low afterwards so a caller can commit later
    task automatic shift(input qdl_word_t w);
        chip_select_n_o = 1'b0;
        #20;
        for (int i = `QDL_WORD_W - 1; i >= 0; i--) begin
            serial_o = w[i];
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
        serial_o = ~serial_o;
    endtask
    task automatic commit();
        #20 chip_select_n_o = 1'b1;
    endtask
    task automatic float_line(input logic on);
        floating_o = on;
    endtask
endmodule
`default_nettype wire

// *** dv/quad_dac_load_control_tb.sv ***
// Purpose: self-checking bench of the quad load logic, serial build
// Assumes: qdl_host_model drives the link pins
// Notes:   fixed waits are sized to the three-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module quad_dac_load_control_tb;
    import qdl_pkg::*;
    logic           clk_i = 1'b0;
    logic           reset_i = 1'b1;
    logic           load_strobe_n = 1'b1;
    logic           clear_all_n = 1'b1;
    wire logic      sclk, cs_n, sdi, sdi_float;
    qdl_bank_t      input_reg, dac_reg, exp_in, exp_dac;
    qdl_chan_mask_t out_enable;
    logic           hw_pd;
    int             failures = 0;
    int             check_count = 0;
    int             cycles = 0;
    logic [31:0]    seed = 32'h913F;
    logic [31:0]    noise = 32'h913F;
    always #5 clk_i = ~clk_i;
    qdl_host_model host_u (.sclk_o(sclk), .chip_select_n_o(cs_n), .serial_o(sdi),
        .floating_o(sdi_float));
    qdl_core #(.SERIAL_MODE(1'b1)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
        .chip_select_n_i(cs_n), .serial_in_or_shutdown_i(sdi), .serial_in_floating_i(sdi_float),
        .load_strobe_n_i(load_strobe_n), .clear_all_n_i(clear_all_n), .write_n_i(noise[12]),
        .addr_hi_i(noise[9]), .addr_lo_or_powerdown_i(noise[8]), .addr_lo_floating_i(1'b0),
        .par_data_i(noise[7:0]), .input_reg_o(input_reg), .dac_reg_o(dac_reg),
        .out_enable_o(out_enable), .hw_powerdown_o(hw_pd));
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // parallel pins wander at random; a serial build must ignore them
    always @(negedge clk_i) noise <= xorshift(noise);
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic finish_word(input qdl_word_t w);
        host_u.commit();
        wait_clk(20);
        exp_in[{w.addr_hi, w.addr_lo}] = w.data;
        if (!load_strobe_n)
            exp_dac = exp_in;
        `CHK(input_reg, exp_in)
        `CHK(dac_reg, exp_dac)
    endtask
    task automatic send_word(input qdl_word_t w);
        host_u.shift(w);
        finish_word(w);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, far above the roughly 800 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        exp_in = '0;
        exp_dac = '0;
        wait_clk(20);
        reset_i = 1'b0;
        wait_clk(5);
        for (int i = 0; i < 12; i++) begin
            seed = xorshift(seed);
            send_word({2'b11, (i < 4) ? i[1:0] : seed[9:8], seed[7:0]});
        end
        `CHK(out_enable, 4'hF)
        load_strobe_n = 1'b0;
        wait_clk(10);
        `CHK(dac_reg, exp_in)
        send_word({2'b11, 2'b01, 8'hA5});
        load_strobe_n = 1'b1;
        send_word({2'b01, 2'b10, 8'h3C});
        `CHK(out_enable, 4'h0)
        send_word({2'b10, 2'b01, 8'hC3});
        `CHK(out_enable[1], 1'b0)
        send_word({2'b11, 2'b01, 8'h5A});
        `CHK(out_enable[1], 1'b1)
        host_u.float_line(1'b1);
        wait_clk(10);
        `CHK(({hw_pd, out_enable}), 5'h10)
        host_u.float_line(1'b0);
        wait_clk(10);
        `CHK(({hw_pd, dac_reg}), ({1'b0, exp_dac}))
        host_u.shift({2'b11, 2'b11, 8'h81});
        wait_clk(1);
        clear_all_n = 1'b0;
        wait_clk(10);
        `CHK(({input_reg, dac_reg}), 64'h0)
        clear_all_n = 1'b1;
        exp_in = '0;
        exp_dac = '0;
        wait_clk(10);
        finish_word({2'b11, 2'b11, 8'h81});
        end_sim();
    end
endmodule
`default_nettype wire

// *** include/qdl_defines.svh ***
// Purpose: constants of the quad converter load and control logic
// Assumes: included by bare name from the package and the design
// Notes:   definitions only
`ifndef QDL_DEFINES_SVH
`define QDL_DEFINES_SVH
`define QDL_CODE_W      8
`define QDL_CHANNELS    4
`define QDL_WORD_W      12
`define QDL_BIT_ALL_N   11
`define QDL_BIT_SEL_N   10
`define QDL_ADDR_HI_BIT 9
`define QDL_ADDR_LO_BIT 8
`define QDL_ZERO_CODE   8'h00
`define QDL_SYNC_DEPTH  3
`endif

// *** include/qdl_pkg.sv ***
// Purpose: shared types of the quad converter load and control logic
// Assumes: qdl_defines.svh on the include path
// Notes:   the serial word is carried as a packed struct
`include "qdl_defines.svh"
package qdl_pkg;
    typedef logic [`QDL_CODE_W-1:0] qdl_code_t;
    typedef struct packed {
        logic      powerdown_every_channel_n;
        logic      powerdown_selected_channel_n;
        logic      addr_hi;
        logic      addr_lo;
        qdl_code_t data;
    } qdl_word_t;
    typedef qdl_code_t [`QDL_CHANNELS-1:0] qdl_bank_t;
    typedef logic [`QDL_CHANNELS-1:0] qdl_chan_mask_t;
endpackage

// *** rtl/qdl_core.sv ***
// Purpose: load and control logic of a quad 8-bit voltage-output converter
// Assumes: serial link clock sclk_i runs only inside frames; pin levels are
//          sampled on clk_i through three flops, a change counts once the
//          second and third flop agree
// Notes:   loads and clears act on clk_i after synchronisation, not truly
//          asynchronously; latency is a few clk_i cycles
//          the link word crosses into clk_i through a holding register loaded
//          one cycle after the synchronised chip select rise, so no bit is
//          read while it may still be moving
//          pin pulses sampled by only one clk_i edge are lost; that trade
//          buys immunity to glitches on slow host wiring
//          shutdown only drops output enables; codes stay in the registers
//          a clear and a write in one cycle: the clear wins
//          floating pins are reported by detectors outside, as plain levels
`timescale 1ns/1ps
`default_nettype none
`include "qdl_defines.svh"
module qdl_core #(
    parameter bit SERIAL_MODE = 1'b1
) (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               sclk_i,
    input  wire logic               chip_select_n_i,
    input  wire logic               serial_in_or_shutdown_i,
    input  wire logic               serial_in_floating_i,
    input  wire logic               load_strobe_n_i,
    input  wire logic               clear_all_n_i,
    input  wire logic               write_n_i,
    input  wire logic               addr_hi_i,
    input  wire logic               addr_lo_or_powerdown_i,
    input  wire logic               addr_lo_floating_i,
    input  wire qdl_pkg::qdl_code_t par_data_i,
    output var  qdl_pkg::qdl_bank_t input_reg_o,
    output var  qdl_pkg::qdl_bank_t dac_reg_o,
    output var  qdl_pkg::qdl_chan_mask_t out_enable_o,
    output logic                    hw_powerdown_o
);
    import qdl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift register on sclk_i, shifts only while selected
    // chip select also clears nothing here, so a clear never touches it
    logic [`QDL_WORD_W-1:0] shift_reg;
    always_ff @(posedge sclk_i or posedge reset_i) begin
        if (reset_i) begin
            shift_reg <= '0;
        end else if (!chip_select_n_i) begin
            shift_reg <= {shift_reg[`QDL_WORD_W-2:0], serial_in_or_shutdown_i};
        end
    end
    // no clear term above; word is stable once chip select is high, so it
    // is sampled in the system domain after the synchronised rising edge

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, change counts when flops two and three agree
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] pin_s1;
    logic [NSYNC-1:0] pin_s2;
    logic [NSYNC-1:0] pin_s3;
    logic [NSYNC-1:0] pin_q;
    assign pin_raw = {chip_select_n_i,
                      load_strobe_n_i,
                      clear_all_n_i,
                      write_n_i,
                      addr_hi_i,
                      addr_lo_or_powerdown_i,
                      SERIAL_MODE ? serial_in_floating_i : addr_lo_floating_i};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    pin_s1[g] <= (g >= 3) ? 1'b1 : 1'b0;
                    pin_s2[g] <= (g >= 3) ? 1'b1 : 1'b0;
                    pin_s3[g] <= (g >= 3) ? 1'b1 : 1'b0;
                    pin_q[g]  <= (g >= 3) ? 1'b1 : 1'b0;
                end else begin
                    pin_s1[g] <= pin_raw[g];
                    pin_s2[g] <= pin_s1[g];
                    pin_s3[g] <= pin_s2[g];
                    if (pin_s2[g] == pin_s3[g]) begin
                        pin_q[g] <= pin_s3[g];
                    end
                end
            end
        end
    endgenerate

    // bit positions of the pins inside the synchroniser bank
    localparam int P_CS    = 6;
    localparam int P_LOAD  = 5;
    localparam int P_CLEAR = 4;
    localparam int P_WR    = 3;
    localparam int P_A_HI  = 2;
    localparam int P_A_LO  = 1;
    localparam int P_FLOAT = 0;

    wire cs_n_q    = pin_q[P_CS];
    wire load_n_q  = pin_q[P_LOAD];
    wire clear_n_q = pin_q[P_CLEAR];
    wire wr_n_q    = pin_q[P_WR];
    wire a_hi_q    = pin_q[P_A_HI];
    wire a_lo_q    = pin_q[P_A_LO];
    wire float_q   = pin_q[P_FLOAT];

    // parallel data bus is sampled twice so the write's data has settled
    qdl_code_t pdata_s1;
    qdl_code_t pdata_s2;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pdata_s1 <= `QDL_ZERO_CODE;
            pdata_s2 <= `QDL_ZERO_CODE;
        end else begin
            pdata_s1 <= par_data_i;
            pdata_s2 <= pdata_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // front end decode
    logic cs_n_d;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_n_d <= 1'b1;
        end else begin
            cs_n_d <= cs_n_q;
        end
    end
    wire       cs_rise   = cs_n_q && !cs_n_d;

    // the shift register belongs to the link clock; it is copied here once the
    // link clock has stopped, and only the copy is decoded on clk_i
    qdl_word_t word_hold;
    qdl_word_t next_word_hold;
    logic      commit_q;

    always_comb begin
        next_word_hold = word_hold;
        if (cs_rise) begin
            next_word_hold = qdl_word_t'(shift_reg);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            word_hold <= '0;
            commit_q  <= 1'b0;
        end else begin
            word_hold <= next_word_hold;
            commit_q  <= cs_rise;
        end
    end

    qdl_word_t word;
    assign word = word_hold;
    wire [1:0] ser_addr  = {word.addr_hi, word.addr_lo};
    wire [1:0] par_addr  = {a_hi_q, a_lo_q};
    wire       ser_write = SERIAL_MODE && commit_q;
    wire       par_write = !SERIAL_MODE && !wr_n_q && !float_q;

    // only one front end exists in a build; the other's pins are ignored
    wire [1:0] sel_addr;
    wire       do_write;
    qdl_code_t wr_data;
    generate
        if (SERIAL_MODE) begin : g_serial_front
            assign sel_addr = ser_addr;
            assign do_write = ser_write;
            assign wr_data  = word.data;
        end else begin : g_parallel_front
            assign sel_addr = par_addr;
            assign do_write = par_write;
            assign wr_data  = pdata_s2;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // input and DAC registers, one slice per channel
    qdl_bank_t in_reg;
    qdl_bank_t dac_reg;
    generate
        for (g = 0; g < `QDL_CHANNELS; g++) begin : g_chan
            wire       hit     = do_write && (sel_addr == 2'(g));
            wire       zero_it = !clear_n_q;
            wire       follow  = !load_n_q;
            qdl_code_t next_in;
            qdl_code_t next_dac;
            // clear outranks a write, so a write in the clear cycle is lost
            assign next_in  = zero_it ? `QDL_ZERO_CODE
                            : hit ? wr_data : in_reg[g];
            // transparent while the strobe is low, independent of chip select
            assign next_dac = zero_it ? `QDL_ZERO_CODE
                            : follow ? in_reg[g] : dac_reg[g];

            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    in_reg[g] <= `QDL_ZERO_CODE;
                end else begin
                    in_reg[g] <= next_in;
                end
            end

            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    dac_reg[g] <= `QDL_ZERO_CODE;
                end else begin
                    dac_reg[g] <= next_dac;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // software shutdown: latched on every serial word, the data still loads
    qdl_chan_mask_t soft_down;
    qdl_chan_mask_t next_soft_down;
    wire            all_off = !word.powerdown_every_channel_n;
    wire            sel_off = !word.powerdown_selected_channel_n;

    generate
        for (g = 0; g < `QDL_CHANNELS; g++) begin : g_down
            wire is_sel = (ser_addr == 2'(g));
            wire off    = all_off || (sel_off && is_sel);
            assign next_soft_down[g] = ser_write ? off : soft_down[g];
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    soft_down[g] <= 1'b0;
                end else begin
                    soft_down[g] <= next_soft_down[g];
                end
            end
        end
    endgenerate

    // hardware shutdown comes from the pin's floating detector
    wire hw_powerdown = float_q;

    ////////////////////////////////////////////////////////////////////////////
    // outputs; shutdown only gates the enables, codes are untouched
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hw_powerdown_o <= 1'b0;
        end else begin
            hw_powerdown_o <= hw_powerdown;
        end
    end

    generate
        for (g = 0; g < `QDL_CHANNELS; g++) begin : g_out
            // an enable low opens the channel; its code stays in dac_reg
            wire down = soft_down[g] || hw_powerdown;
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    out_enable_o[g] <= 1'b0;
                end else begin
                    out_enable_o[g] <= !down;
                end
            end
        end
    endgenerate

    assign input_reg_o = in_reg;
    assign dac_reg_o   = dac_reg;
endmodule
`default_nettype wire
